// *** ufm_map.vh ***
// ufm_map.vh: offsets, reset values, field positions and pointer ranges
// assumes: included by bare name from the ufm slave design files
`ifndef UFM_MAP_VH
`define UFM_MAP_VH

// register offsets reached through the pointer
`define UFM_OFS_PRIMARY   7'h00
`define UFM_OFS_GROUP1    7'h3A
`define UFM_OFS_GROUP2    7'h3B
`define UFM_OFS_GROUP3    7'h3C
`define UFM_OFS_BCAST     7'h3D
`define UFM_OFS_LAST      7'h3E

// reset values
`define UFM_RST_PRIMARY   8'h09
`define UFM_RST_BCAST     8'hE0
`define UFM_RST_GROUP     8'hEE
`define UFM_RST_CTRL      8'h00

// primary_config_reg fields
`define UFM_BIT_BCAST_EN  0
`define UFM_BIT_GRP3_EN   1
`define UFM_BIT_GRP2_EN   2
`define UFM_BIT_GRP1_EN   3
`define UFM_BIT_RANGE_LO  5
`define UFM_BIT_RANGE_HI  6

// register_pointer_control fields
`define UFM_BIT_INCR_FLAG 7

// increment modes {incr_flag, incr_range_hi, incr_range_lo}
`define UFM_MODE_FIXED    3'h0
`define UFM_MODE_ALL      3'h4
`define UFM_MODE_BRIGHT   3'h5
`define UFM_MODE_GAIN     3'h6
`define UFM_MODE_GLOBAL   3'h7

// pointer ranges per mode
`define UFM_ALL_LO        7'h00
`define UFM_ALL_HI        7'h3E
`define UFM_BRIGHT_LO     7'h0A
`define UFM_BRIGHT_HI     7'h21
`define UFM_GAIN_LO       7'h00
`define UFM_GAIN_HI       7'h39
`define UFM_GLOBAL_LO     7'h08
`define UFM_GLOBAL_HI     7'h21

// serial framing
`define UFM_BITS_BYTE     4'h8
`define UFM_ACK_SLOT      4'h8

`endif

// *** ufm_sync.v ***
// ufm_sync.v: two-flop synchroniser for a group of slow external levels
// assumes: each bit is an independent level; no word coherence needed
`timescale 1ns/1ps
`default_nettype none

module ufm_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input  wire             clock,
  input  wire             rstn,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_r <= INIT;
      dout   <= INIT;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule

`default_nettype wire

// *** ufm_slave.v ***
// ufm_slave.v: write-only ultra fast-mode serial slave with pointer control
// assumes: master drives both bus lines push-pull; bus clock far below clock
// assumes: the register bank behind wr_en_r decodes its own offsets
// Operation
// R1: accept own, broadcast or enabled group address
// R2: writes only; direction bit must be zero
// R3: broadcast address resets E0h, enabled, writable
// R4: master avoids broadcast default as slave address
// R5: three group addresses reset to EEh
// R6: group one enabled, two and three disabled
// R7: group defaults usable only while disabled
// R8: master takes care with reserved addresses
// R9: first byte after match is control byte
// R10: bits 6..0 pointer, bit 7 increment flag
// R11: range bits come from primary config bits
// R12: flag set advances pointer after each write
// R13: mode 000 keeps pointer fixed
// R14: mode 100 runs 00h to 3Eh
// R15: mode 101 runs 0Ah to 21h
// R16: mode 110 runs 00h to 39h
// R17: mode 111 runs 08h to 21h
// R18: master never uses modes 001, 010, 011
// R19: increment touches only seven pointer bits
// R20: first write goes to pointer, any address
// R21: start below range climbs then wraps low
// R22: unused addresses discarded, pointer still moves
`timescale 1ns/1ps
`default_nettype none
`include "ufm_map.vh"

module ufm_slave (
  input  wire       clock,
  input  wire       rstn,
  input  wire       bus_clk,
  input  wire       bus_data,
  input  wire [6:0] own_addr,
  output reg        wr_en_r,
  output reg  [6:0] wr_addr_r,
  output reg  [7:0] wr_data_r,
  output reg  [7:0] register_pointer_control,
  output reg  [7:0] primary_config_reg,
  output reg  [7:0] broadcast_addr_reg,
  output reg  [7:0] group_addr_reg_1,
  output reg  [7:0] group_addr_reg_2,
  output reg  [7:0] group_addr_reg_3,
  output reg        selected_r
);

  // one-hot receive states
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_ADDR = 5'h02;
  localparam [4:0] ST_CTRL = 5'h04;
  localparam [4:0] ST_DATA = 5'h08;
  localparam [4:0] ST_SKIP = 5'h10;

  wire [8:0] sync_out;
  wire       scl_s;
  wire       sda_s;
  wire [6:0] own_s;

  reg  [4:0] state_r;
  reg  [4:0] state_nxt;
  reg        scl_d_r;
  reg        sda_d_r;
  reg  [3:0] bit_cnt_r;
  reg  [6:0] shift_r;

  wire       scl_rise;
  wire       start_seen;
  wire       stop_seen;
  wire       byte_done;
  wire [7:0] rx_byte;
  wire       addr_hit;
  wire [2:0] incr_mode;
  wire [6:0] ptr;
  wire       ctrl_done;
  wire       data_done;

  // bus lines and straps cross into the clock domain
  // straps share the pipeline; they settle once after power-up
  ufm_sync #(
    .WIDTH (9),
    .INIT  (9'h003)
  ) u_sync (
    .clock (clock),
    .rstn  (rstn),
    .din   ({own_addr, bus_data, bus_clk}),
    .dout  (sync_out)
  );

  assign scl_s = sync_out[0];
  assign sda_s = sync_out[1];
  assign own_s = sync_out[8:2];

  // next pointer for a given mode; reserved modes hold the pointer
  // a pointer at or past the last register falls back to the range low end
  function [6:0] next_ptr;
    input [6:0] cur;
    input [2:0] mode;
    reg   [6:0] lo;
    reg   [6:0] hi;
    reg         step;
    begin
      lo   = `UFM_ALL_LO;
      hi   = `UFM_ALL_HI;
      step = 1'b1;
      case (mode)
        `UFM_MODE_ALL: begin
          lo = `UFM_ALL_LO;                              // [R14]
          hi = `UFM_ALL_HI;
        end
        `UFM_MODE_BRIGHT: begin
          lo = `UFM_BRIGHT_LO;                           // [R15]
          hi = `UFM_BRIGHT_HI;
        end
        `UFM_MODE_GAIN: begin
          lo = `UFM_GAIN_LO;                             // [R16]
          hi = `UFM_GAIN_HI;
        end
        `UFM_MODE_GLOBAL: begin
          lo = `UFM_GLOBAL_LO;                           // [R17]
          hi = `UFM_GLOBAL_HI;
        end
        default: step = 1'b0;                            // [R13] [R18]
      endcase
      // wrap on the range end or from any pointer at or past the last register
      if (!step) begin
        next_ptr = cur;
      end else if (cur == hi || cur >= `UFM_OFS_LAST) begin
        next_ptr = lo;                                   // [R21]
      end else begin
        next_ptr = cur + 7'h01;                          // [R12] [R21]
      end
    end
  endfunction

  // start, stop and rising clock edges from the synchronised lines
  // both lines pass the same pipeline, so their relative order is kept
  assign scl_rise   = scl_s & ~scl_d_r;
  assign start_seen = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_seen  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign byte_done  = scl_rise && (bit_cnt_r == `UFM_BITS_BYTE - 4'h1);
  assign rx_byte    = {shift_r, sda_s};

  // ends of control and data bytes within a matched transfer
  assign ctrl_done  = byte_done && (state_r == ST_CTRL);
  assign data_done  = byte_done && (state_r == ST_DATA);

  // one compare: enabled and equal to the upper seven bits of a held address
  function addr_match;
    input [6:0] addr;
    input [7:0] held;
    input       en;
    begin
      addr_match = en && (addr == held[7:1]);
    end
  endfunction

  // address match against own, enabled broadcast and enabled group addresses;
  // bit 0 of the held address registers is a don't-care
  assign addr_hit = (rx_byte[0] == 1'b0) &&                       // [R2]
    ((rx_byte[7:1] == own_s) ||                                   // [R1]
     addr_match(rx_byte[7:1], broadcast_addr_reg,
                primary_config_reg[`UFM_BIT_BCAST_EN]) ||         // [R1] [R3]
     addr_match(rx_byte[7:1], group_addr_reg_1,
                primary_config_reg[`UFM_BIT_GRP1_EN]) ||          // [R1] [R6]
     addr_match(rx_byte[7:1], group_addr_reg_2,
                primary_config_reg[`UFM_BIT_GRP2_EN]) ||          // [R6]
     addr_match(rx_byte[7:1], group_addr_reg_3,
                primary_config_reg[`UFM_BIT_GRP3_EN]));           // [R6]

  // increment mode from control flag and primary config range bits
  // range bits written by a data byte steer steps from the next byte on
  assign incr_mode = {register_pointer_control[`UFM_BIT_INCR_FLAG],
                      primary_config_reg[`UFM_BIT_RANGE_HI],
                      primary_config_reg[`UFM_BIT_RANGE_LO]};     // [R11]
  assign ptr = register_pointer_control[6:0];                    // [R10]

  // line history and bit counter; the ninth clock is the ack slot
  // this slave never drives the ack slot, so that bit is simply dropped
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      scl_d_r   <= 1'b1;
      sda_d_r   <= 1'b1;
      bit_cnt_r <= 4'h0;
      shift_r   <= 7'h00;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      if (start_seen || stop_seen) begin
        bit_cnt_r <= 4'h0;
      end else if (scl_rise) begin
        if (bit_cnt_r == `UFM_ACK_SLOT) begin
          bit_cnt_r <= 4'h0;
        end else begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
          shift_r   <= {shift_r[5:0], sda_s};
        end
      end
    end
  end

  // receive state machine
  // start and stop take priority over a byte end in the same cycle
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_ADDR: begin
        if (byte_done) begin
          state_nxt = addr_hit ? ST_CTRL : ST_SKIP;      // [R1] [R2]
        end
      end
      ST_CTRL: begin
        if (byte_done) begin
          state_nxt = ST_DATA;                           // [R9]
        end
      end
      default: state_nxt = state_r;
    endcase
    if (start_seen) begin
      state_nxt = ST_ADDR;
    end else if (stop_seen) begin
      state_nxt = ST_IDLE;
    end
  end

  // state register
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // control byte capture and pointer progression
  // the flag bit is loaded only by a control byte, never by stepping
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      register_pointer_control <= `UFM_RST_CTRL;
    end else if (ctrl_done) begin
      register_pointer_control <= rx_byte;               // [R9] [R10] [R20]
    end else if (data_done) begin
      register_pointer_control[6:0] <= next_ptr(ptr, incr_mode); // [R12] [R19]
    end
  end

  // write strobe to the register bank; unused addresses raise none
  // address and data stay put until the next data byte, used address or not
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_en_r   <= 1'b0;
      wr_addr_r <= 7'h00;
      wr_data_r <= 8'h00;
    end else begin
      wr_en_r <= 1'b0;
      if (data_done) begin
        wr_en_r   <= (ptr <= `UFM_OFS_LAST);             // [R22]
        wr_addr_r <= ptr;                                // [R20]
        wr_data_r <= rx_byte;
      end
    end
  end

  // locally held registers that steer addressing and increment range
  // they are volatile: any reset returns them to their defaults
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      primary_config_reg <= `UFM_RST_PRIMARY;            // [R6]
      broadcast_addr_reg <= `UFM_RST_BCAST;              // [R3]
      group_addr_reg_1   <= `UFM_RST_GROUP;              // [R5]
      group_addr_reg_2   <= `UFM_RST_GROUP;
      group_addr_reg_3   <= `UFM_RST_GROUP;
    end else if (data_done) begin
      if (ptr == `UFM_OFS_PRIMARY) begin
        primary_config_reg <= rx_byte;                   // [R11]
      end else if (ptr == `UFM_OFS_BCAST) begin
        broadcast_addr_reg <= rx_byte;                   // [R3]
      end else if (ptr == `UFM_OFS_GROUP1) begin
        group_addr_reg_1 <= rx_byte;                     // [R5]
      end else if (ptr == `UFM_OFS_GROUP2) begin
        group_addr_reg_2 <= rx_byte;
      end else if (ptr == `UFM_OFS_GROUP3) begin
        group_addr_reg_3 <= rx_byte;
      end
    end
  end

  // selected while a matched transfer is in progress
  // follows the next state, so it rises with the control phase
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      selected_r <= 1'b0;
    end else begin
      selected_r <= (state_nxt == ST_CTRL) || (state_nxt == ST_DATA);
    end
  end

endmodule

`default_nettype wire

// *** ufm_slave_properties.sv ***
// checker for the serial write slave: strobes, pointer stepping, address regs
// assumes: bound to ufm_slave and watching its ports only
`timescale 1ns/1ps
`default_nettype none
module ufm_slave_checker (
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       wr_en_r,
  input wire logic [6:0] wr_addr_r,
  input wire logic [7:0] wr_data_r,
  input wire logic [7:0] register_pointer_control,
  input wire logic [7:0] primary_config_reg,
  input wire logic [7:0] broadcast_addr_reg,
  input wire logic [7:0] group_addr_reg_1,
  input wire logic       selected_r
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // pointer and flag views of the control byte
  wire logic [6:0] ptr  = register_pointer_control[6:0];
  wire logic       flag = register_pointer_control[7];
  // next pointer for a range select
  function automatic logic [6:0] step(input logic [6:0] p, input logic [1:0] r);
    logic [6:0] lo;
    logic [6:0] hi;
    lo = (r == 2'h1) ? 7'h0A : (r == 2'h3) ? 7'h08 : 7'h00;
    hi = (r == 2'h0) ? 7'h3E : (r == 2'h2) ? 7'h39 : 7'h21;
    return (p == hi || p >= 7'h3E) ? lo : p + 7'h01;
  endfunction
  sequence pulse_s;
    wr_en_r ##1 !wr_en_r;
  endsequence
  sequence in_frame_s;
    wr_en_r && selected_r;
  endsequence
  pulse_once_a: assert property ($rose(wr_en_r) |-> pulse_s)
    else $error("write strobe too long");
  used_addr_a: assert property (wr_en_r |-> wr_addr_r <= 7'h3E)
    else $error("write to unused address");
  write_sel_a: assert property (wr_en_r |-> in_frame_s)
    else $error("write outside transfer");
  flag_kept_a: assert property (wr_en_r |-> $stable(flag))
    else $error("flag changed by increment");
  hold_ptr_a: assert property (wr_en_r && !flag |-> ptr == wr_addr_r)
    else $error("pointer moved in fixed mode");
  step_ptr_a: assert property (
    wr_en_r && flag |-> ptr == step(wr_addr_r, $past(primary_config_reg[6:5])))
    else $error("pointer stepped wrongly");
  bcast_load_a: assert property (
    wr_en_r && wr_addr_r == 7'h3D |-> ##[0:1] broadcast_addr_reg == wr_data_r)
    else $error("broadcast address not loaded");
  group_load_a: assert property (
    wr_en_r && wr_addr_r == 7'h3A |-> ##[0:1] group_addr_reg_1 == wr_data_r)
    else $error("group address not loaded");
  ctrl_idle_a: assert property (
    !selected_r && !$past(selected_r) |-> $stable(register_pointer_control))
    else $error("control changed outside transfer");
endmodule
bind ufm_slave ufm_slave_checker ufm_slave_checker_i (.clock, .rstn, .wr_en_r, .wr_addr_r,
  .wr_data_r, .register_pointer_control, .primary_config_reg, .broadcast_addr_reg,
  .group_addr_reg_1, .selected_r);
`default_nettype wire

// *** ufm_master_model.sv ***
// bus master model: start, bytes and stop, writes only
// assumes: 800 ns bus clock, lines idle high, tasks called by the bench
`timescale 1ns/1ps
`default_nettype none
module ufm_master_model (
  output var logic bus_clk,
  output var logic bus_data
);
  // idle bus
  initial begin
    bus_clk = 1'b1;
    bus_data = 1'b1;
  end
  // start: data falls while the clock is high
  task automatic begin_frame();
    #400 bus_data = 1'b0;
    #400 bus_clk = 1'b0;
  endtask
  // msb first, ninth slot driven with the inverse of the last bit
  task automatic put_byte(input logic [7:0] b);
    for (int i = 0; i < 9; i++) begin
      bus_data = (i == 8) ? ~b[0] : b[7 - i];
      #200 bus_clk = 1'b1;
      #400 bus_clk = 1'b0;
      #200;
    end
  endtask
  // stop: data rises while the clock is high; clock then stands high
  task automatic end_frame();
    bus_data = 1'b0;
    #200 bus_clk = 1'b1;
    #400 bus_data = 1'b1;
    #400;
  endtask
endmodule
`default_nettype wire

// *** ufm_write_slave_addr_pointer_bench.sv ***
// bench: master model sends write frames, captured strobes are compared
// assumes: slave, master model and bound checker compiled before it
`timescale 1ns/1ps
`default_nettype none
module ufm_write_slave_addr_pointer_bench;
  logic       clock;
  logic       rstn;
  logic [6:0] own_addr;
  logic [7:0] cfg;
  logic [7:0] g2;
  logic [7:0] bc;
  logic [6:0] exp_a[$];
  logic [7:0] exp_d[$];
  logic [6:0] got_a[$];
  logic [7:0] got_d[$];
  logic [6:0] starts[4] = '{7'h3A, 7'h05, 7'h36, 7'h1F};
  int         err_total;
  int         samples_checked;
  wire        bus_clk;
  wire        bus_data;
  wire        wr_en_r;
  wire        selected_r;
  wire [6:0]  wr_addr_r;
  wire [7:0]  wr_data_r, ctrl, pcfg, bcast, grp1, grp2, grp3;
  ufm_master_model ufm_master_model_i (.bus_clk, .bus_data);
  ufm_slave ufm_slave_i (.clock, .rstn, .bus_clk, .bus_data, .own_addr, .wr_en_r, .wr_addr_r,
    .wr_data_r, .register_pointer_control(ctrl), .primary_config_reg(pcfg),
    .broadcast_addr_reg(bcast), .group_addr_reg_1(grp1), .group_addr_reg_2(grp2),
    .group_addr_reg_3(grp3), .selected_r);
  // system clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // capture each write strobe mid-cycle, where it has settled
  always @(negedge clock) begin
    if (wr_en_r === 1'b1) begin
      got_a.push_back(wr_addr_r);
      got_d.push_back(wr_data_r);
    end
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge clock);
    err_total++;
    results();
  end
  function automatic logic [6:0] step(input logic [6:0] p, input logic [1:0] r);
    logic [6:0] lo;
    logic [6:0] hi;
    lo = (r == 2'h1) ? 7'h0A : (r == 2'h3) ? 7'h08 : 7'h00;
    hi = (r == 2'h0) ? 7'h3E : (r == 2'h2) ? 7'h39 : 7'h21;
    return (p == hi || p >= 7'h3E) ? lo : p + 7'h01;
  endfunction
  // data per target: address and config regs keep what the bench tracks
  function automatic logic [7:0] dat(input logic [6:0] p);
    if (p == 7'h00) return cfg;
    if (p == 7'h3B) return g2;
    if (p == 7'h3D) return bc;
    if (p == 7'h3A || p == 7'h3C) return 8'hEE;
    return 8'($urandom);
  endfunction
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  // one frame: address byte, control byte, n data bytes, then compare
  task automatic xfer(input logic [7:0] ab, input logic [7:0] cb, input int n, input bit hit);
    logic [6:0] p;
    logic [7:0] d;
    p = cb[6:0];
    got_a.delete();
    got_d.delete();
    exp_a.delete();
    exp_d.delete();
    @(posedge clock);
    #1 ufm_master_model_i.begin_frame();
    ufm_master_model_i.put_byte(ab);
    ufm_master_model_i.put_byte(cb);
    chk("selected", {7'h00, hit}, {7'h00, selected_r});
    repeat (n) begin
      d = dat(p);
      ufm_master_model_i.put_byte(d);
      if (hit && p <= 7'h3E) begin
        exp_a.push_back(p);
        exp_d.push_back(d);
      end
      if (cb[7]) p = step(p, cfg[6:5]);
    end
    ufm_master_model_i.end_frame();
    repeat (4) @(posedge clock);
    chk("selected", 8'h00, {7'h00, selected_r});
    chk("write count", 8'(exp_a.size()), 8'(got_a.size()));
    foreach (exp_a[i]) begin
      chk("write address", {1'b0, exp_a[i]}, {1'b0, got_a[i]});
      chk("write data", exp_d[i], got_d[i]);
    end
    if (hit) chk("control", {cb[7], p}, ctrl);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    rstn = 1'b0;
    own_addr = 7'h51;
    cfg = 8'h09;
    g2 = 8'hEE;
    bc = 8'hE0;
    err_total = 0;
    samples_checked = 0;
    void'($urandom(32'hd4551773));
    repeat (16) @(posedge clock);
    #1 own_addr = 7'h51 + 7'($urandom % 15);
    rstn = 1'b1;
    repeat (4) @(posedge clock);
    chk("config", 8'h09, pcfg);
    chk("broadcast", 8'hE0, bcast);
    chk("group 1", 8'hEE, grp1);
    chk("group 3", 8'hEE, grp3);
    chk("control", 8'h00, ctrl);
    for (int m = 0; m < 4; m++) begin
      cfg = {1'b0, 2'(m), 5'h09};
      xfer({own_addr, 1'b0}, 8'h80, 1, 1);
      xfer({own_addr, 1'b0}, {1'b1, starts[m]}, 30, 1);
    end
    cfg = 8'h09;
    xfer({own_addr, 1'b0}, 8'h80, 1, 1);
    xfer({own_addr, 1'b0}, {1'b0, 7'h0A + 7'($urandom % 24)}, 3, 1);
    xfer(8'hE0, 8'h8A, 3, 1);
    xfer(8'hEE, 8'h90, 3, 1);
    g2 = 8'hC0;
    xfer({own_addr, 1'b0}, 8'h3B, 1, 1);
    chk("group 2", 8'hC0, grp2);
    xfer(8'hC0, 8'h8A, 2, 0);
    cfg = 8'h0D;
    xfer({own_addr, 1'b0}, 8'h80, 1, 1);
    xfer(8'hC0, 8'h8A, 2, 1);
    xfer({own_addr, 1'b1}, 8'h8A, 2, 0);
    xfer({~own_addr, 1'b0}, 8'h8A, 2, 0);
    xfer({own_addr, 1'b0}, 8'hC0, 2, 1);
    bc = 8'hE2;
    xfer({own_addr, 1'b0}, 8'h3D, 1, 1);
    chk("broadcast", bc, bcast);
    xfer(8'hE2, 8'h8A, 1, 1);
    xfer(8'hE0, 8'h8A, 1, 0);
    cfg = 8'h01;
    xfer({own_addr, 1'b0}, 8'h80, 1, 1);
    xfer(8'hEE, 8'h8A, 1, 0);
    cfg = 8'h02;
    xfer({own_addr, 1'b0}, 8'h80, 1, 1);
    xfer(8'hEE, 8'h8A, 1, 1);
    xfer(8'hE2, 8'h8A, 1, 0);
    // mid-run reset: volatile address registers return to defaults
    @(posedge clock);
    #1 rstn = 1'b0;
    repeat (2) @(posedge clock);
    #1 rstn = 1'b1;
    repeat (4) @(posedge clock);
    chk("broadcast", 8'hE0, bcast);
    chk("group 2", 8'hEE, grp2);
    chk("config", 8'h09, pcfg);
    chk("control", 8'h00, ctrl);
    results();
  end
endmodule
`default_nettype wire
